/* File: rtl/tpo_outputs.sv */
// Purpose: Three hysteretic relay outputs and one shared open-collector output
//   that is either a scaled pulse train or a hysteretic level.
// Assumes: i_params is synchronous to i_core_clk; AXI4-Lite slave.
// Notes: Unit 3 of the comparator bank serves the shared output in level mode.
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module tpo_outputs (
  input wire logic i_core_clk,                 // Core clock, 250 MHz.
  input wire logic i_rst,                      // Async reset, active high.
  input wire tpo_pkg::tpo_bank_t i_params,     // Internal drive parameters.
  input wire logic [7:0] i_s_axi_awaddr,       // Write address.
  input wire logic i_s_axi_awvalid,            // Write address valid.
  output logic o_s_axi_awready,                // Write address ready.
  input wire logic [31:0] i_s_axi_wdata,       // Write data.
  input wire logic [3:0] i_s_axi_wstrb,        // Write byte strobes.
  input wire logic i_s_axi_wvalid,             // Write data valid.
  output logic o_s_axi_wready,                 // Write data ready.
  output logic [1:0] o_s_axi_bresp,            // Write response.
  output logic o_s_axi_bvalid,                 // Write response valid.
  input wire logic i_s_axi_bready,             // Write response ready.
  input wire logic [7:0] i_s_axi_araddr,       // Read address.
  input wire logic i_s_axi_arvalid,            // Read address valid.
  output logic o_s_axi_arready,                // Read address ready.
  output logic [31:0] o_s_axi_rdata,           // Read data.
  output logic [1:0] o_s_axi_rresp,            // Read response.
  output logic o_s_axi_rvalid,                 // Read data valid.
  input wire logic i_s_axi_rready,             // Read data ready.
  output logic [2:0] o_relay,                  // Relay coils, high energized.
  output logic o_oc_sink                       // Open collector, high sinks.
);

  tpo_pkg::tpo_cfg_bank_t cfg_q, cfg_d;
  tpo_pkg::tpo_mode_t mode_q, mode_d;
  logic [15:0] gain_q, gain_d, bias_q, bias_d;

  logic awready_q, awready_d, wready_q, wready_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic do_wr;

  logic [3:0] state_q, state_d;
  logic inv [4];
  logic signed [16:0] src_v [4];
  logic signed [16:0] cmp_v [4];

  logic [17:0] freq_q, freq_d;
  logic [27:0] acc_q, acc_d;
  logic tgl_q, tgl_d, oc_q, oc_d;
  logic signed [39:0] prod_w, pct_w, hz_w;

  // Readback of one register word; bit 32 flags a mapped address.
  function automatic logic [32:0] reg_word(input logic [7:0] a);
    logic [32:0] r;
    r = 33'h0_0000_0000;
    for (int i = 0; i < tpo_pkg::TPO_NUM_CMP; i++) begin
      if (a == ((i < tpo_pkg::TPO_NUM_RELAY) ?
          8'(tpo_pkg::TPO_RLY_BASE + 8'(i) * tpo_pkg::TPO_RLY_STRIDE) :
          tpo_pkg::TPO_OC_SEL)) begin
        r[32] = 1'b1;
        r[tpo_pkg::TPO_SEL_W-1:0] = cfg_q[i].sel;
        r[tpo_pkg::TPO_SEL_ABS_BIT] = cfg_q[i].abs_en;
      end
      if (a == ((i < tpo_pkg::TPO_NUM_RELAY) ?
          8'(tpo_pkg::TPO_RLY_BASE + 8'(i) * tpo_pkg::TPO_RLY_STRIDE
             + tpo_pkg::TPO_SUB_ON) : tpo_pkg::TPO_OC_ON)) begin
        r = {1'b1, {16{cfg_q[i].on_thr[15]}}, cfg_q[i].on_thr};
      end
      if (a == ((i < tpo_pkg::TPO_NUM_RELAY) ?
          8'(tpo_pkg::TPO_RLY_BASE + 8'(i) * tpo_pkg::TPO_RLY_STRIDE
             + tpo_pkg::TPO_SUB_OFF) : tpo_pkg::TPO_OC_OFF)) begin
        r = {1'b1, {16{cfg_q[i].off_thr[15]}}, cfg_q[i].off_thr};
      end
    end
    unique case (a)
      tpo_pkg::TPO_CTRL: begin
        r = {1'b1, 31'h0000_0000, mode_q == tpo_pkg::TPO_MODE_LEVEL};
      end
      tpo_pkg::TPO_OC_GAIN: r = {1'b1, 16'h0000, gain_q};
      tpo_pkg::TPO_OC_BIAS: r = {1'b1, 16'h0000, bias_q};
      tpo_pkg::TPO_STAT: begin
        r = {1'b1, 27'h000_0000, oc_q, state_q};
      end
      tpo_pkg::TPO_FREQ: r = {1'b1, 14'h0000, freq_q};
      default: ;
    endcase
    return r;
  endfunction : reg_word

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
    return m;
  endfunction : merge

  // Bus slave: address and data are taken in either order, then answered.
  assign do_wr = aw_got_q & w_got_q & ~bvalid_q;

  always_comb begin
    logic [32:0] rw;
    rw = reg_word(i_s_axi_araddr);
    awready_d = awready_q;
    wready_d = wready_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (i_s_axi_awvalid && awready_q) begin
      awready_d = 1'b0;
      aw_got_d = 1'b1;
      awaddr_d = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && wready_q) begin
      wready_d = 1'b0;
      w_got_d = 1'b1;
      wdata_d = i_s_axi_wdata;
      wstrb_d = i_s_axi_wstrb;
    end
    if (do_wr) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = reg_word(awaddr_q)[32] ? tpo_pkg::TPO_RESP_OKAY :
                tpo_pkg::TPO_RESP_SLVERR;
    end
    if (bvalid_q && i_s_axi_bready) begin
      bvalid_d = 1'b0;
      awready_d = 1'b1;
      wready_d = 1'b1;
    end
    if (i_s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = rw[31:0];
      rresp_d = rw[32] ? tpo_pkg::TPO_RESP_OKAY : tpo_pkg::TPO_RESP_SLVERR;
    end
    if (rvalid_q && i_s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= tpo_pkg::TPO_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= tpo_pkg::TPO_RESP_OKAY;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Configuration writes; gain and bias saturate at 300 percent.
  always_comb begin
    logic [31:0] v;
    logic [7:0] base;
    v = merge(reg_word(awaddr_q)[31:0], wdata_q, wstrb_q);
    base = 8'h00;
    cfg_d = cfg_q;
    mode_d = mode_q;
    gain_d = gain_q;
    bias_d = bias_q;
    if (do_wr) begin
      for (int i = 0; i < tpo_pkg::TPO_NUM_CMP; i++) begin
        base = (i < tpo_pkg::TPO_NUM_RELAY) ?
          8'(tpo_pkg::TPO_RLY_BASE + 8'(i) * tpo_pkg::TPO_RLY_STRIDE) :
          tpo_pkg::TPO_OC_SEL;
        if (awaddr_q == base) begin
          cfg_d[i].sel = v[tpo_pkg::TPO_SEL_W-1:0];
          cfg_d[i].abs_en = v[tpo_pkg::TPO_SEL_ABS_BIT];
        end
        if (awaddr_q == ((i < tpo_pkg::TPO_NUM_RELAY) ?
            8'(base + tpo_pkg::TPO_SUB_ON) : tpo_pkg::TPO_OC_ON)) begin
          cfg_d[i].on_thr = v[15:0];
        end
        if (awaddr_q == ((i < tpo_pkg::TPO_NUM_RELAY) ?
            8'(base + tpo_pkg::TPO_SUB_OFF) : tpo_pkg::TPO_OC_OFF)) begin
          cfg_d[i].off_thr = v[15:0];
        end
      end
      unique case (awaddr_q)
        tpo_pkg::TPO_CTRL: begin
          mode_d = v[tpo_pkg::TPO_CTRL_LEVEL_BIT] ? tpo_pkg::TPO_MODE_LEVEL :
                   tpo_pkg::TPO_MODE_PULSE;
        end
        tpo_pkg::TPO_OC_GAIN: begin
          gain_d = (v[15:0] > tpo_pkg::TPO_PCT_MAX) ? tpo_pkg::TPO_PCT_MAX :
                   v[15:0];
        end
        tpo_pkg::TPO_OC_BIAS: begin
          bias_d = (v[15:0] > tpo_pkg::TPO_PCT_MAX) ? tpo_pkg::TPO_PCT_MAX :
                   v[15:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_q <= tpo_pkg::TPO_CFG_RST;
      mode_q <= tpo_pkg::TPO_MODE_PULSE;
      gain_q <= tpo_pkg::TPO_GAIN_RST;
      bias_q <= tpo_pkg::TPO_BIAS_RST;
    end else begin
      cfg_q <= cfg_d;
      mode_q <= mode_d;
      gain_q <= gain_d;
      bias_q <= bias_d;
    end
  end

  // Hysteretic comparators. A unit whose on threshold lies below its off
  // threshold is taken as inverted, so a false source energizes it.
  for (genvar g = 0; g < tpo_pkg::TPO_NUM_CMP; g++) begin : g_cmp
    always_comb begin
      logic signed [16:0] on_v, off_v;
      src_v[g] = 17'(signed'(i_params[cfg_q[g].sel]));
      cmp_v[g] = (cfg_q[g].abs_en && src_v[g] < 0) ? -src_v[g] :
                 src_v[g];
      on_v = 17'(cfg_q[g].on_thr);
      off_v = 17'(cfg_q[g].off_thr);
      inv[g] = on_v < off_v;
      state_d[g] = state_q[g];
      if (!inv[g]) begin
        if (cmp_v[g] >= on_v) begin
          state_d[g] = 1'b1;
        end else if (cmp_v[g] <= off_v) begin
          state_d[g] = 1'b0;
        end
      end else begin
        if (cmp_v[g] <= on_v) begin
          state_d[g] = 1'b1;
        end else if (cmp_v[g] >= off_v) begin
          state_d[g] = 1'b0;
        end
      end
      // Level thresholds have no say in pulse-train mode.
      if (g == tpo_pkg::TPO_LVL_UNIT && mode_q != tpo_pkg::TPO_MODE_LEVEL) begin
        state_d[g] = 1'b0;
      end
    end
  end

  // Frequency in Hz: (gain * source / full + bias) scaled to full-scale Hz.
  // Negative results clamp to zero; the pin does not run backwards.
  always_comb begin
    prod_w = 40'(signed'({1'b0, gain_q})) *
             40'(src_v[tpo_pkg::TPO_LVL_UNIT]);
    // Every operand is kept signed so a negative product is not read as a
    // huge unsigned number.
    pct_w = prod_w / signed'(40'(tpo_pkg::TPO_PCT_FULL)) +
            signed'(40'(bias_q));
    hz_w = pct_w * signed'(40'(tpo_pkg::TPO_FMAX_HZ)) /
           signed'(40'(tpo_pkg::TPO_PCT_FULL));
    freq_d = 18'h0_0000;
    if (mode_q == tpo_pkg::TPO_MODE_PULSE && hz_w > 0) begin
      freq_d = hz_w[17:0];
    end
    // Phase accumulator toggles the pin twice per output period.
    acc_d = 28'h000_0000;
    tgl_d = 1'b0;
    if (mode_q == tpo_pkg::TPO_MODE_PULSE) begin
      acc_d = acc_q + 28'(freq_q);
      tgl_d = tgl_q;
      if (acc_d >= tpo_pkg::TPO_HALF_CYC) begin
        acc_d = acc_d - tpo_pkg::TPO_HALF_CYC;
        tgl_d = ~tgl_q;
      end
    end
    oc_d = (mode_q == tpo_pkg::TPO_MODE_LEVEL) ?
           state_d[tpo_pkg::TPO_LVL_UNIT] : tgl_d;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= 4'h0;
      freq_q <= 18'h0_0000;
      acc_q <= 28'h000_0000;
      tgl_q <= 1'b0;
      oc_q <= 1'b0;
    end else begin
      state_q <= state_d;
      freq_q <= freq_d;
      acc_q <= acc_d;
      tgl_q <= tgl_d;
      oc_q <= oc_d;
    end
  end

  assign o_relay = state_q[2:0];
  assign o_oc_sink = oc_q;
  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready = wready_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;
  assign o_s_axi_rvalid = rvalid_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_rly_on;
    !inv[0] && cmp_v[0] >= 17'(cfg_q[0].on_thr) |=> o_relay[0];
  endproperty
  a_rly_on: assert property (p_rly_on) else $error("relay0 not on");

  property p_rly_off;
    !inv[1] && cmp_v[1] <= 17'(cfg_q[1].off_thr) &&
      cmp_v[1] < 17'(cfg_q[1].on_thr) |=> !o_relay[1];
  endproperty
  a_rly_off: assert property (p_rly_off) else $error("relay1 not off");

  property p_hold;
    !inv[2] && cmp_v[2] > 17'(cfg_q[2].off_thr) &&
      cmp_v[2] < 17'(cfg_q[2].on_thr) |=> $stable(o_relay[2]);
  endproperty
  a_hold: assert property (p_hold) else $error("relay2 lost state");

  property p_abs;
    cfg_q[0].abs_en |-> cmp_v[0] >= 0;
  endproperty
  a_abs: assert property (p_abs) else $error("magnitude negative");

  property p_level_pin;
    mode_q == tpo_pkg::TPO_MODE_LEVEL ##1 mode_q == tpo_pkg::TPO_MODE_LEVEL
      |-> o_oc_sink == state_q[tpo_pkg::TPO_LVL_UNIT];
  endproperty
  a_level_pin: assert property (p_level_pin) else $error("pin vs level");

  property p_level_quiet;
    mode_q == tpo_pkg::TPO_MODE_LEVEL |=> freq_q == 18'h0_0000 &&
      acc_q == 28'h000_0000;
  endproperty
  a_level_quiet: assert property (p_level_quiet) else $error("freq live");

  property p_full_scale;
    mode_q == tpo_pkg::TPO_MODE_PULSE && gain_q == tpo_pkg::TPO_PCT_FULL &&
      bias_q == 16'h0000 &&
      src_v[tpo_pkg::TPO_LVL_UNIT] == 17'(tpo_pkg::TPO_PCT_FULL)
      |=> freq_q == 18'(tpo_pkg::TPO_FMAX_HZ);
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("not 10kHz");

  property p_pulse_mode;
    mode_q == tpo_pkg::TPO_MODE_PULSE |=> !state_q[tpo_pkg::TPO_LVL_UNIT];
  endproperty
  a_pulse_mode: assert property (p_pulse_mode) else $error("level live");

  property p_rd_answer;
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read data");

  property p_bhold;
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");

  c_rly_rise: cover property ($rose(o_relay[0]));
  c_pulse: cover property (mode_q == tpo_pkg::TPO_MODE_PULSE ##1
    $rose(o_oc_sink));
  c_level: cover property (mode_q == tpo_pkg::TPO_MODE_LEVEL ##1 o_oc_sink);
  c_write: cover property (o_s_axi_bvalid && i_s_axi_bready);

endmodule : tpo_outputs

/* File: inc/tpo_pkg.sv */
// Purpose: Constants, register map and carrier types for the relay, level
//   and pulse-train output stage.
// Assumes: Source values are signed 16-bit words in 0.01 units (10000 is
//   100 percent, 1 is true, 0 is false).
// Notes: Contract
// Contract
// - Each relay picks its source from any internal parameter via a selector.
// - Each relay compares its source against its own on and off thresholds.
// - Absolute-value option replaces the relay source by its magnitude first.
// - Relay energizes when compared value is at or above its on threshold.
// - Relay de-energizes when compared value is at or below its off threshold.
// - Each relay's energized state is readable and not writable.
// - Third relay defaults inverted: on threshold false, off threshold true.
// - Shared output runs pulse-train or level mode; pulse-train after reset.
// - Pulse-train mode outputs a frequency derived from the selected source.
// - Gain 100% on source 100% gives full 10kHz; gain spans 0 to 300%.
// - Bias, percent of 10kHz over 0 to 300%, sets the minimum frequency; the code lets a negative source pull it below bias, down to zero.
// - Pulse-train mode shows the present output frequency as read-only status.
// - Level mode drives the shared output fully on or off like a relay.
// - Level mode absolute-value option takes the source magnitude first.
// - Level mode turns on at or above on threshold, default 0.01.
// - Level mode turns off at or below off threshold, default 0.00.
// - Level mode shows the present on or off state as read-only status.

package tpo_pkg;

  localparam int TPO_NUM_SRC = 16;
  localparam int TPO_SEL_W = 4;
  localparam int TPO_VAL_W = 16;
  localparam int TPO_NUM_RELAY = 3;
  localparam int TPO_NUM_CMP = 4;
  localparam int TPO_LVL_UNIT = 3;
  localparam int TPO_ADDR_W = 8;

  typedef logic [TPO_NUM_SRC-1:0][TPO_VAL_W-1:0] tpo_bank_t;

  typedef struct packed {
    logic [TPO_SEL_W-1:0] sel;
    logic abs_en;
    logic signed [TPO_VAL_W-1:0] on_thr;
    logic signed [TPO_VAL_W-1:0] off_thr;
  } tpo_cmp_cfg_t;

  typedef tpo_cmp_cfg_t [TPO_NUM_CMP-1:0] tpo_cfg_bank_t;

  typedef enum logic [1:0] {
    TPO_MODE_PULSE = 2'b01,
    TPO_MODE_LEVEL = 2'b10
  } tpo_mode_t;

  // Value scale and defaults.
  localparam logic signed [15:0] TPO_TRUE = 16'sh0001;
  localparam logic signed [15:0] TPO_FALSE = 16'sh0000;
  localparam logic signed [15:0] TPO_LVL_ON_RST = 16'sh0001;
  localparam logic signed [15:0] TPO_LVL_OFF_RST = 16'sh0000;
  localparam logic [15:0] TPO_PCT_FULL = 16'h2710;
  localparam logic [15:0] TPO_PCT_MAX = 16'h7530;
  localparam logic [15:0] TPO_GAIN_RST = 16'h2710;
  localparam logic [15:0] TPO_BIAS_RST = 16'h0000;
  localparam logic [15:0] TPO_FMAX_HZ = 16'h2710;

  // Timing: clock period and derived rate for the pulse synthesiser.
  localparam int TPO_CLK_PERIOD_PS = 4000;
  localparam longint TPO_CLK_HZ = 64'd1000000000000 / TPO_CLK_PERIOD_PS;
  localparam int TPO_ACC_W = 28;
  localparam int TPO_FREQ_W = 18;
  localparam logic [27:0] TPO_HALF_CYC = 28'(TPO_CLK_HZ / 2);

  // Register byte offsets.
  localparam logic [7:0] TPO_CTRL = 8'h00;
  localparam logic [7:0] TPO_RLY_BASE = 8'h10;
  localparam logic [7:0] TPO_RLY_STRIDE = 8'h10;
  localparam logic [7:0] TPO_SUB_SEL = 8'h00;
  localparam logic [7:0] TPO_SUB_ON = 8'h04;
  localparam logic [7:0] TPO_SUB_OFF = 8'h08;
  localparam logic [7:0] TPO_OC_SEL = 8'h40;
  localparam logic [7:0] TPO_OC_GAIN = 8'h44;
  localparam logic [7:0] TPO_OC_BIAS = 8'h48;
  localparam logic [7:0] TPO_OC_ON = 8'h4C;
  localparam logic [7:0] TPO_OC_OFF = 8'h50;
  localparam logic [7:0] TPO_STAT = 8'h60;
  localparam logic [7:0] TPO_FREQ = 8'h64;

  // Field positions.
  localparam int TPO_CTRL_LEVEL_BIT = 0;
  localparam int TPO_SEL_ABS_BIT = 8;
  localparam int TPO_STAT_LVL_BIT = 3;
  localparam int TPO_STAT_PIN_BIT = 4;

  localparam logic [1:0] TPO_RESP_OKAY = 2'h0;
  localparam logic [1:0] TPO_RESP_SLVERR = 2'h2;

  localparam tpo_cfg_bank_t TPO_CFG_RST = '{
    '{4'h3, 1'b0, TPO_LVL_ON_RST, TPO_LVL_OFF_RST},
    '{4'h2, 1'b0, TPO_FALSE, TPO_TRUE},
    '{4'h1, 1'b0, TPO_TRUE, TPO_FALSE},
    '{4'h0, 1'b0, TPO_TRUE, TPO_FALSE}
  };

endpackage : tpo_pkg

/* File: test/tpo_load_model.sv */
// Purpose: Far-side loads: relay coils and a pulse receiver on the open
//   collector.
// Assumes: Sink edges are seen in the core clock domain.
// Notes: The count clears on i_clear so the bench can gate a window.
`timescale 1ns/1ps

module tpo_load_model (
  input wire logic i_core_clk,      // Core clock.
  input wire logic i_rst,           // Async reset, active high.
  input wire logic [2:0] i_relay,   // Relay coil drives.
  input wire logic i_oc_sink,       // Open collector sink.
  input wire logic i_clear,         // Clears the pulse count.
  output logic [2:0] o_coil,        // Coil state seen by the loads.
  output logic [31:0] o_rise_cnt    // Rising sink edges counted.
);
  logic sink_q;

  assign o_coil = i_relay;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sink_q <= 1'b0;
      o_rise_cnt <= 32'h0000_0000;
    end else begin
      sink_q <= i_oc_sink;
      if (i_clear) begin
        o_rise_cnt <= 32'h0000_0000;
      end else if (i_oc_sink && !sink_q) begin
        o_rise_cnt <= o_rise_cnt + 32'h0000_0001;
      end
    end
  end
endmodule : tpo_load_model

/* File: test/test_threshold_and_pulse_outputs.sv */
// Purpose: Self-checking bench for the relay, level and pulse outputs.
// Assumes: Expected values come from the bench's own reference functions and literal tables.
// Notes: Pulse count is judged over a window, as the rate is an average.
`timescale 1ns/1ps

module test_threshold_and_pulse_outputs;
  localparam int RA[15] = '{0, 16, 20, 24, 32, 36, 40, 48, 52, 56, 64, 68,
    72, 76, 80};
  localparam int RV[15] = '{0, 0, 1, 0, 1, 1, 0, 2, 0, 1, 3, 10000, 0, 1, 0};
  logic core_clk, rst, clr, awvalid, wvalid, bready, arvalid, rready;
  tpo_pkg::tpo_bank_t params;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [31:0] wdata, rdata, rises;
  logic awready, wready, bvalid, arready, rvalid, oc_sink;
  logic [1:0] bresp, rresp;
  logic [2:0] relay, coil;
  int err_total, checks;

  tpo_outputs u_dut (.i_core_clk(core_clk), .i_rst(rst), .i_params(params),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_relay(relay),
    .o_oc_sink(oc_sink));
  tpo_load_model u_load (.i_core_clk(core_clk), .i_rst(rst), .i_relay(relay),
    .i_oc_sink(oc_sink), .i_clear(clr), .o_coil(coil), .o_rise_cnt(rises));

  always #2 core_clk = ~core_clk;

  task automatic report_and_stop;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic hang(input string nm);
    err_total++;
    $display("[ERR] %s expected answer seen timeout", nm);
    report_and_stop();
  endtask : hang

  task automatic wr(input logic [7:0] a, input int d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) break;
    end
    if (n == 100) hang("bvalid");
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) break;
    end
    if (n == 100) hang("rvalid");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input string nm, input int a, input int e);
    logic [31:0] d;
    logic [1:0] r;
    rd(8'(a), d, r);
    chk(nm, 32'(e), d);
  endtask : rchk

  task automatic set_src(input int k, input int v);
    @(posedge core_clk);
    params[k] <= 16'(v);
    repeat (3) @(posedge core_clk);
  endtask : set_src

  task automatic pin_case(input int v, input bit e);
    set_src(3, v);
    chk("oc pin", 32'(e), 32'(oc_sink));
  endtask : pin_case

  function automatic bit rly_ref(bit p, int v, bit ab, int on, int off);
    int x;
    x = (ab && v < 0) ? -v : v;
    if (on >= off) return (x >= on) ? 1'b1 : ((x <= off) ? 1'b0 : p);
    return (x <= on) ? 1'b1 : ((x >= off) ? 1'b0 : p);
  endfunction : rly_ref

  function automatic int freq_ref(int g, int s, int b);
    int f;
    f = g * s / 10000 + b;
    return (f < 0) ? 0 : f;
  endfunction : freq_ref

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int on, off, k, v, g, b, a;
    bit ab, eq;
    {core_clk, clr, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, params} = '0;
    wstrb = 4'hf;
    rst = 1'b1;
    err_total = 0;
    checks = 0;
    k = $urandom(32'h0392_0260);
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    foreach (RA[i]) rchk("reset value", RA[i], RV[i]);
    chk("relays idle", 32'h0000_0004, 32'(coil));
    wr(tpo_pkg::TPO_STAT, -1, r);
    chk("status bresp", 32'(tpo_pkg::TPO_RESP_OKAY), 32'(r));
    rchk("status", tpo_pkg::TPO_STAT, 4);
    rd(8'h80, d, r);
    chk("unmapped rresp", 32'(tpo_pkg::TPO_RESP_SLVERR), 32'(r));
    wr(8'h80, 5, r);
    chk("unmapped bresp", 32'(tpo_pkg::TPO_RESP_SLVERR), 32'(r));
    for (int rl = 0; rl < 3; rl++) begin
      k = $urandom_range(15, 0);
      ab = 1'($urandom_range(1, 0));
      on = $urandom_range(3000, 1000);
      off = on - $urandom_range(900, 0);
      a = 16 + 16 * rl;
      wr(8'(a), k + (int'(ab) << 8), r);
      wr(8'(a + 4), on, r);
      wr(8'(a + 8), off, r);
      rchk("selector", a, k + (int'(ab) << 8));
      rchk("off threshold", a + 8, off);
      eq = 1'b0;
      for (int st = 0; st < 10; st++) begin
        case (st % 5)
          0: v = on;
          2: v = off;
          4: v = -on - $urandom_range(50, 0);
          default: v = (on + off) / 2;
        endcase
        set_src(k, v);
        eq = rly_ref(eq, v, ab, on, off);
        chk("relay", 32'(eq), 32'(coil[rl]));
      end
    end
    wr(tpo_pkg::TPO_OC_GAIN, 40000, r);
    rchk("gain ceiling", tpo_pkg::TPO_OC_GAIN, 30000);
    // Only the low byte lane is written; the high byte keeps its value.
    wstrb <= 4'h1;
    wr(tpo_pkg::TPO_OC_GAIN, 32'h0000_0011, r);
    wstrb <= 4'hf;
    rchk("gain lane", tpo_pkg::TPO_OC_GAIN, 32'h0000_7511);
    for (int i = 0; i < 7; i++) begin
      g = (i == 0) ? 10000 : $urandom_range(30000, 0);
      b = (i == 0) ? 0 : $urandom_range(30000, 0);
      v = (i == 0) ? 10000 : $urandom_range(65535, 0) - 32768;
      if (i == 6) {g, b, v} = {30000, 30000, 32767};
      wr(tpo_pkg::TPO_OC_GAIN, g, r);
      wr(tpo_pkg::TPO_OC_BIAS, b, r);
      set_src(3, v);
      rchk("freq", tpo_pkg::TPO_FREQ, freq_ref(g, v, b));
    end
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (20000) @(posedge core_clk);
    chk("pulse count", 1, 32'(rises >= 9 && rises <= 11));
    wr(tpo_pkg::TPO_CTRL, 1, r);
    rchk("freq in level", tpo_pkg::TPO_FREQ, 0);
    pin_case(0, 1'b0);
    pin_case(1, 1'b1);
    rd(tpo_pkg::TPO_STAT, d, r);
    chk("level status", 3, 32'(d[4:3]));
    wr(tpo_pkg::TPO_OC_ON, 300, r);
    wr(tpo_pkg::TPO_OC_OFF, 100, r);
    wr(tpo_pkg::TPO_OC_SEL, 3 + 256, r);
    pin_case(-300, 1'b1);
    pin_case(-200, 1'b1);
    wr(tpo_pkg::TPO_OC_GAIN, 0, r);
    chk("gain ignored", 1, 32'(oc_sink));
    pin_case(100, 1'b0);
    pin_case(200, 1'b0);
    report_and_stop();
  end
endmodule : test_threshold_and_pulse_outputs
